/* File: pkg/awd_pkg.sv */
// Functional notes
// - Axis detects when delta exceeds its threshold
// - Separate threshold per axis, others untouched
// - Threshold is six bits, zero to 63
// - Optional event counter gates each axis flag
// - Six shadow registers written through one port
// - Index 000/100 none, then thresholds, counts
// - Count field holds events minus one
// - Axis flags combine by AND or OR
// - OR combining: any active axis wakes
// - AND combining: all active axes needed
// - Powered-down axes leave the combination
// - Default delta: current minus previous sample
// - Baseline delta: first sample, held in mode
// - Shadow index sits in config bits 2:0
// - Eleven-bit delta, clamped six-bit slice compared
package awd_pkg;

  // ************************************************
  // Register indices, byte address is four times
  // ************************************************
  localparam int AWD_ADDR_W = 10;
  localparam logic [7:0] AWD_IDX_AXIS_CTRL = 8'h10;
  localparam logic [7:0] AWD_IDX_THR_CTRL = 8'h13;
  localparam logic [7:0] AWD_IDX_CONFIG = 8'h14;
  localparam logic [7:0] AWD_IDX_STATUS = 8'h18;
  localparam logic [7:0] AWD_IDX_MASK = 8'h19;
  localparam logic [7:0] AWD_IDX_STATE = 8'h1a;

  // ************************************************
  // Field positions and widths
  // ************************************************
  localparam int AWD_MODE_BIT = 7;
  localparam int AWD_ANDOR_BIT = 6;
  localparam int AWD_PWRDN_LSB = 4;
  localparam int AWD_MUX_LSB = 4;
  localparam int AWD_CNTEN_BIT = 3;
  localparam int AWD_KIND_BIT = 2;
  localparam int AWD_TH_W = 6;
  localparam int AWD_DELTA_W = 11;
  localparam int AWD_SAMPLE_W = 12;
  localparam int AWD_ST_W = 4;
  localparam int AWD_ST_AXIS_LSB = 1;
  localparam int AWD_ST_WAKE = 0;

  // ************************************************
  // Codes and reset values
  // ************************************************
  localparam logic [2:0] AWD_IDX_TH_X = 3'h1;
  localparam logic [2:0] AWD_IDX_CNT_Z = 3'h7;
  localparam logic [1:0] AWD_IDX_NONE = 2'h0;
  localparam logic [1:0] AWD_AXIS_OFS = 2'h1;
  localparam logic [2:0] AWD_MUX_MAX = 3'h5;
  localparam logic [2:0] AWD_AXES_ALL = 3'h7;
  localparam logic [5:0] AWD_TH_MAX = 6'h3f;
  localparam logic [5:0] AWD_SHADOW_RST = 6'h00;

  // Per-axis settings handed to each detector
  typedef struct packed {
    logic base_ref;
    logic [2:0] mux;
    logic cnten;
    logic [AWD_TH_W-1:0] thresh;
    logic [AWD_TH_W-1:0] count;
  } awd_axis_cfg_type;

  // Detector phase within the monitoring mode
  typedef enum logic [1:0] {AWD_IDLE, AWD_PRIME, AWD_RUN} awd_phase_type;

endpackage : awd_pkg

/* File: rtl/awd_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module awd_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Event and software clear
  input wire logic set,
  input wire logic clr,
  // Sticky state
  output logic bit_q
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (srst) begin
      bit_q <= 1'b0;
    end else if (set) begin
      bit_q <= 1'b1;
    end else if (clr) begin
      bit_q <= 1'b0;
    end
  end

  a_set_wins: assert property (@(posedge clk) disable iff (srst) set |=> bit_q)
    else $error("sticky bit lost an event");

endmodule : awd_flag
`default_nettype wire

/* File: rtl/awd_axis.sv */
`timescale 1ns/1ps
`default_nettype none
module awd_axis
  import awd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sample stream
  input wire logic mon_active,
  input wire logic smp_valid,
  input wire logic [AWD_SAMPLE_W-1:0] smp,
  // Settings
  input wire awd_axis_cfg_type cfg,
  // Results, held until the next judged sample; cleared when monitoring stops
  output logic det_q,
  output logic flag_q
);

  // ************************************************
  // Delta path
  // ************************************************
  awd_phase_type phase_q; // Monitoring phase
  logic [AWD_SAMPLE_W-1:0] prev_q; // Last sample
  logic [AWD_SAMPLE_W-1:0] base_q; // Baseline sample
  logic [AWD_TH_W-1:0] run_q; // Consecutive detections so far
  logic [AWD_SAMPLE_W-1:0] ref_c;
  logic [AWD_SAMPLE_W:0] diff_c;
  logic [AWD_SAMPLE_W:0] mag_c;
  logic [AWD_DELTA_W-1:0] delta_c;
  logic [AWD_DELTA_W-1:0] shift_c;
  logic [2:0] sel_c;
  logic [AWD_TH_W-1:0] slice_c;
  logic hit_c;
  logic eval_c;

  // Magnitude of the difference, clamped so big swings still detect
  always_comb begin
    ref_c = cfg.base_ref ? base_q : prev_q;
    diff_c = {smp[AWD_SAMPLE_W-1], smp} - {ref_c[AWD_SAMPLE_W-1], ref_c};
    mag_c = diff_c[AWD_SAMPLE_W] ? -diff_c : diff_c;
    delta_c = (|mag_c[AWD_SAMPLE_W:AWD_DELTA_W]) ? '1 : mag_c[AWD_DELTA_W-1:0];
    sel_c = (cfg.mux > AWD_MUX_MAX) ? AWD_MUX_MAX : cfg.mux;
    shift_c = delta_c >> sel_c;
    slice_c = (|shift_c[AWD_DELTA_W-1:AWD_TH_W]) ? '1 : shift_c[AWD_TH_W-1:0];
    hit_c = slice_c > cfg.thresh;
  end

  // A sample is judged only once a reference exists
  assign eval_c = smp_valid && mon_active && (phase_q == AWD_RUN);

  // ************************************************
  // Phase and references
  // ************************************************
  // First sample after entry primes the references
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= AWD_IDLE;
    end else begin
      unique case (phase_q)
        AWD_IDLE: if (mon_active) phase_q <= AWD_PRIME;
        AWD_PRIME: begin
          if (!mon_active) phase_q <= AWD_IDLE;
          else if (smp_valid) phase_q <= AWD_RUN;
        end
        AWD_RUN: if (!mon_active) phase_q <= AWD_IDLE;
      endcase
    end
  end

  // Previous sample tracks every sample while monitoring; baseline only at entry
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= '0;
      base_q <= '0;
    end else if (smp_valid && mon_active) begin
      prev_q <= smp;
      if (phase_q != AWD_RUN) base_q <= smp;
    end
  end

  // ************************************************
  // Detection and event counting
  // ************************************************
  // A miss restarts the run, so counted events are consecutive
  always_ff @(posedge clk) begin
    if (srst || !mon_active) begin
      det_q <= 1'b0;
      flag_q <= 1'b0;
      run_q <= '0;
    end else if (eval_c) begin
      det_q <= hit_c;
      flag_q <= hit_c && (!cfg.cnten || run_q >= cfg.count);
      if (!hit_c) run_q <= '0;
      else if (run_q != AWD_TH_MAX) run_q <= run_q + 1'b1;
    end
  end

  a_detect_strict: assert property (@(posedge clk) disable iff (srst)
    eval_c |=> det_q == $past(hit_c))
    else $error("detection does not follow threshold compare");
  a_count_gate: assert property (@(posedge clk) disable iff (srst)
    (eval_c && cfg.cnten && run_q < cfg.count) |=> !flag_q)
    else $error("flag raised before event count met");
  a_base_hold: assert property (@(posedge clk) disable iff (srst)
    (phase_q == AWD_RUN && mon_active) |=> $stable(base_q))
    else $error("baseline moved during monitoring");
  a_clamp_hit: assert property (@(posedge clk) disable iff (srst)
    (eval_c && |delta_c[AWD_DELTA_W-1:AWD_TH_W] && cfg.mux == '0 && cfg.thresh != AWD_TH_MAX) |=> det_q)
    else $error("clamped delta not detected");

endmodule : awd_axis
`default_nettype wire

/* File: rtl/awd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module awd_top
  import awd_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AWD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Samples from the sensor core
  input wire logic MON_ACTIVE,
  input wire logic SAMPLE_VALID,
  input wire logic [AWD_SAMPLE_W-1:0] SAMPLE_X,
  input wire logic [AWD_SAMPLE_W-1:0] SAMPLE_Y,
  input wire logic [AWD_SAMPLE_W-1:0] SAMPLE_Z,
  // Wakeup outputs
  output logic WAKE,
  output logic IRQ
);

  // ************************************************
  // Register state
  // ************************************************
  logic [2:0] pwr_down_q; // Axis power-down bits
  logic mode_q; // Baseline delta when set
  logic and_or_q; // AND combining when set
  logic [2:0][AWD_TH_W-1:0] th_q; // Shadow thresholds
  logic [2:0][AWD_TH_W-1:0] cnt_q; // Shadow counts
  logic [2:0] mux_q; // Delta window select
  logic cnten_q; // Counter enable
  logic [2:0] idx_q; // Shadow index field
  logic [AWD_ST_W-1:0] mask_q; // Interrupt mask
  logic [AWD_ST_W-1:0] status_q; // Sticky events
  logic wake_q; // Registered wakeup level
  logic [2:0] flag_prev_q; // Flags one cycle back

  // ************************************************
  // Bus decode
  // ************************************************
  logic [7:0] reg_c; // Register index from the word address
  logic hit_c; // Mapped index
  logic setup_c; // First cycle of a transfer
  logic wr_c; // Write takes effect
  logic [1:0] ax_c; // Axis chosen by the index
  logic shadow_c; // Index names a shadow register
  logic [31:0] rd_c; // Read value
  logic [AWD_TH_W-1:0] shadow_rd_c; // Selected shadow readback

  assign reg_c = PADDR[AWD_ADDR_W-1:2];
  assign setup_c = PSEL && !PENABLE;
  assign wr_c = PSEL && PENABLE && PWRITE;
  // Index low bits 00 pick nothing, otherwise the axis
  assign shadow_c = idx_q[1:0] != AWD_IDX_NONE;
  assign ax_c = idx_q[1:0] - AWD_AXIS_OFS;

  // Every access finishes without wait states
  assign PREADY = 1'b1;

  // Known indices; anything else answers with an error
  always_comb begin
    unique case (reg_c)
      AWD_IDX_AXIS_CTRL, AWD_IDX_THR_CTRL, AWD_IDX_CONFIG,
      AWD_IDX_STATUS, AWD_IDX_MASK, AWD_IDX_STATE: hit_c = 1'b1;
      default: hit_c = 1'b0;
    endcase
  end

  // Readback of the shadow named by the index
  always_comb begin
    shadow_rd_c = '0;
    if (shadow_c) begin
      shadow_rd_c = idx_q[AWD_KIND_BIT] ? cnt_q[ax_c] : th_q[ax_c];
    end
  end

  // ************************************************
  // Detectors
  // ************************************************
  awd_axis_cfg_type cfg_c [3]; // Per-axis settings
  logic [AWD_SAMPLE_W-1:0] smp_c [3]; // Per-axis sample
  logic [2:0] det_c; // Raw detection per axis
  logic [2:0] flag_c; // Axis flag after counting

  assign smp_c[0] = SAMPLE_X;
  assign smp_c[1] = SAMPLE_Y;
  assign smp_c[2] = SAMPLE_Z;

  // One detector per axis, all sharing mode and window
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign cfg_c[a] = '{base_ref: mode_q, mux: mux_q, cnten: cnten_q,
                        thresh: th_q[a], count: cnt_q[a]};
    awd_axis u_axis (
      .clk(CORE_CLK),
      .srst(SRST),
      .mon_active(MON_ACTIVE),
      .smp_valid(SAMPLE_VALID),
      .smp(smp_c[a]),
      .cfg(cfg_c[a]),
      .det_q(det_c[a]),
      .flag_q(flag_c[a])
    );
  end

  // ************************************************
  // Combination of axis flags
  // ************************************************
  logic [2:0] act_c; // Axes taking part
  logic or_c;
  logic and_c;
  logic wake_c;

  // With every axis powered down nothing can wake
  always_comb begin
    act_c = ~pwr_down_q;
    or_c = |(flag_c & act_c);
    and_c = (|act_c) && (&(flag_c | pwr_down_q));
    wake_c = and_or_q ? and_c : or_c;
  end

  // Registered level keeps the output glitch free
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wake_q <= 1'b0;
      flag_prev_q <= '0;
    end else begin
      wake_q <= wake_c;
      flag_prev_q <= flag_c;
    end
  end

  assign WAKE = wake_q;

  // ************************************************
  // Write side of the register file
  // ************************************************
  // Axis control and threshold control mode bits
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pwr_down_q <= '0;
      mode_q <= 1'b0;
      and_or_q <= 1'b0;
    end else if (wr_c && reg_c == AWD_IDX_AXIS_CTRL) begin
      pwr_down_q <= PWDATA[AWD_PWRDN_LSB +: 3];
    end else if (wr_c && reg_c == AWD_IDX_THR_CTRL) begin
      mode_q <= PWDATA[AWD_MODE_BIT];
      and_or_q <= PWDATA[AWD_ANDOR_BIT];
    end
  end

  // Shadow write goes only where the index points
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      th_q <= {3{AWD_SHADOW_RST}};
      cnt_q <= {3{AWD_SHADOW_RST}};
    end else if (wr_c && reg_c == AWD_IDX_THR_CTRL && shadow_c) begin
      if (idx_q[AWD_KIND_BIT]) begin
        cnt_q[ax_c] <= PWDATA[AWD_TH_W-1:0];
      end else begin
        th_q[ax_c] <= PWDATA[AWD_TH_W-1:0];
      end
    end
  end

  // Configuration: window, counter enable, shadow index
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      mux_q <= '0;
      cnten_q <= 1'b0;
      idx_q <= '0;
    end else if (wr_c && reg_c == AWD_IDX_CONFIG) begin
      mux_q <= PWDATA[AWD_MUX_LSB +: 3];
      cnten_q <= PWDATA[AWD_CNTEN_BIT];
      idx_q <= PWDATA[2:0];
    end
  end

  // Mask has the status layout
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      mask_q <= '0;
    end else if (wr_c && reg_c == AWD_IDX_MASK) begin
      mask_q <= PWDATA[AWD_ST_W-1:0];
    end
  end

  // ************************************************
  // Interrupt status
  // ************************************************
  logic [AWD_ST_W-1:0] set_c; // Rising edges of wake and flags
  logic [AWD_ST_W-1:0] clr_c; // Write one to clear

  assign set_c = {flag_c & ~flag_prev_q, wake_c & ~wake_q};
  assign clr_c = (wr_c && reg_c == AWD_IDX_STATUS) ? PWDATA[AWD_ST_W-1:0] : '0;

  for (genvar s = 0; s < AWD_ST_W; s++) begin : g_status
    awd_flag u_flag (
      .clk(CORE_CLK),
      .srst(SRST),
      .set(set_c[s]),
      .clr(clr_c[s]),
      .bit_q(status_q[s])
    );
  end

  // Level output while any unmasked event is pending
  assign IRQ = |(status_q & mask_q);

  // ************************************************
  // Read side
  // ************************************************
  // Unmapped indices read zero; reserved bits read zero
  always_comb begin
    rd_c = '0;
    unique case (reg_c)
      AWD_IDX_AXIS_CTRL: rd_c[AWD_PWRDN_LSB +: 3] = pwr_down_q;
      AWD_IDX_THR_CTRL: rd_c[7:0] = {mode_q, and_or_q, shadow_rd_c};
      AWD_IDX_CONFIG: rd_c[6:0] = {mux_q, cnten_q, idx_q};
      AWD_IDX_STATUS: rd_c[AWD_ST_W-1:0] = status_q;
      AWD_IDX_MASK: rd_c[AWD_ST_W-1:0] = mask_q;
      AWD_IDX_STATE: rd_c[6:0] = {det_c, wake_q, flag_c};
      default: rd_c = '0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else if (setup_c) begin
      PRDATA <= PWRITE ? '0 : rd_c;
      PSLVERR <= !hit_c;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  a_thr_write_x: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && idx_q == AWD_IDX_TH_X)
    |=> th_q[0] == $past(PWDATA[AWD_TH_W-1:0]))
    else $error("x threshold not loaded from low data bits");
  a_cnt_write_z: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && idx_q == AWD_IDX_CNT_Z)
    |=> cnt_q[2] == $past(PWDATA[AWD_TH_W-1:0]))
    else $error("z count not loaded through the index");
  a_none_index: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && idx_q[1:0] == AWD_IDX_NONE)
    |=> $stable(th_q) && $stable(cnt_q))
    else $error("empty index changed a shadow");
  a_axes_apart: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && idx_q == AWD_IDX_TH_X)
    |=> th_q[2:1] == $past(th_q[2:1]))
    else $error("x threshold write touched y or z");
  a_index_field: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_CONFIG) |=> idx_q == $past(PWDATA[2:0]))
    else $error("index not taken from config bits");
  a_or_wake: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!and_or_q && |(flag_c & ~pwr_down_q)) |=> wake_q ##0 status_q[AWD_ST_WAKE] || $past(wake_q))
    else $error("or combining missed an active axis");
  a_and_wake: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (and_or_q && (flag_c | pwr_down_q) != AWD_AXES_ALL) |=> !wake_q)
    else $error("and combining woke with an axis missing");
  a_powerdown_drop: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (pwr_down_q == AWD_AXES_ALL) |=> !wake_q)
    else $error("powered-down axes still woke");
  a_reset_clear: assert property (@(posedge CORE_CLK)
    SRST |=> (th_q == '0 && cnt_q == '0 && !mode_q && !and_or_q))
    else $error("shadows or mode bits not cleared by reset");

  // ************************************************
  // Register and event checks
  // ************************************************
  // A threshold write lands on the axis the index names
  a_thr_write_any: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && shadow_c && !idx_q[AWD_KIND_BIT])
    |=> th_q[$past(ax_c)] == $past(PWDATA[AWD_TH_W-1:0]))
    else $error("threshold write missed the indexed axis");
  // A count write lands on the axis the index names
  a_cnt_write_any: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && shadow_c && idx_q[AWD_KIND_BIT])
    |=> cnt_q[$past(ax_c)] == $past(PWDATA[AWD_TH_W-1:0]))
    else $error("count write missed the indexed axis");
  // Threshold codes never reach the counts
  a_thr_keeps_cnt: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && !idx_q[AWD_KIND_BIT]) |=> $stable(cnt_q))
    else $error("threshold code changed a count");
  // Count codes never reach the thresholds
  a_cnt_keeps_thr: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL && idx_q[AWD_KIND_BIT]) |=> $stable(th_q))
    else $error("count code changed a threshold");
  // Delta method follows every threshold control write
  a_mode_write: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL) |=> mode_q == $past(PWDATA[AWD_MODE_BIT]))
    else $error("delta method not taken from the write");
  // Combine select follows every threshold control write
  a_combine_write: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_THR_CTRL) |=> and_or_q == $past(PWDATA[AWD_ANDOR_BIT]))
    else $error("combine select not taken from the write");
  // Power-down bits come from the axis control write
  a_pwrdn_write: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_AXIS_CTRL) |=> pwr_down_q == $past(PWDATA[AWD_PWRDN_LSB +: 3]))
    else $error("power-down bits not taken from the write");
  // OR combining stays low with no active flag
  a_or_quiet: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!and_or_q && (flag_c & ~pwr_down_q) == '0) |=> !wake_q)
    else $error("or combining woke with no active flag");
  // AND combining wakes once every active axis is flagged
  a_and_all: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (and_or_q && pwr_down_q != AWD_AXES_ALL && (flag_c | pwr_down_q) == AWD_AXES_ALL)
    |=> wake_q)
    else $error("and combining missed a full set of flags");
  // A wake edge always leaves its sticky bit set
  a_wake_event: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wake_c && !wake_q) |=> status_q[AWD_ST_WAKE])
    else $error("wake edge not recorded");
  // An X flag edge always leaves its sticky bit set
  a_flag_event: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (flag_c[0] && !flag_prev_q[0]) |=> status_q[AWD_ST_AXIS_LSB])
    else $error("axis flag edge not recorded");
  // Writing a one clears the wake bit when no new edge arrives
  a_status_clear: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_STATUS && PWDATA[AWD_ST_WAKE] && !(wake_c && !wake_q))
    |=> !status_q[AWD_ST_WAKE])
    else $error("wake bit not cleared by a one");
  // Mask takes the written layout
  a_mask_write: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (wr_c && reg_c == AWD_IDX_MASK) |=> mask_q == $past(PWDATA[AWD_ST_W-1:0]))
    else $error("mask not taken from the write");
  // Error flag reflects the decode seen in the setup cycle
  a_slverr_map: assert property (@(posedge CORE_CLK) disable iff (SRST)
    setup_c |=> PSLVERR == !$past(hit_c))
    else $error("error flag does not match the decode");
  // Writes hand back zero read data
  a_write_rd_zero: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (setup_c && PWRITE) |=> PRDATA == '0)
    else $error("write returned read data");

endmodule : awd_top
`default_nettype wire

/* File: verification/awd_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module awd_top_test;
  import awd_pkg::*;

  // ************************************************
  // Stimulus and observed signals
  // ************************************************
  logic clk, srst, psel, pen, pwrite, mon, sv;
  logic [AWD_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, wake, irq, err;
  logic [AWD_SAMPLE_W-1:0] sx, sy, sz;
  logic mode, andor, cnten; // Bench copies of mode, combine and count enable
  int n_errors, checks_done, cycles;

  awd_top uut (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MON_ACTIVE(mon), .SAMPLE_VALID(sv), .SAMPLE_X(sx), .SAMPLE_Y(sy), .SAMPLE_Z(sz),
    .WAKE(wake), .IRQ(irq));

  // ************************************************
  // Clock, timeout and closing report
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about 400 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ************************************************
  // APB master and register helpers
  // ************************************************
  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // If pready never rises, only the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  // Select a shadow, then write it with the current mode and combine bits
  task automatic shw(input logic [2:0] idx, input logic [5:0] val);
    apb(1'b1, AWD_IDX_CONFIG, {28'h0, cnten, idx});
    apb(1'b1, AWD_IDX_THR_CTRL, {24'h0, mode, andor, val});
  endtask : shw

  // ************************************************
  // Sample stream helpers
  // ************************************************
  // Leave and re-enter monitoring; next sample only primes the references
  task automatic enter();
    @(posedge clk);
    mon <= 1'b0;
    repeat (2) @(posedge clk);
    mon <= 1'b1;
  endtask : enter

  // Send one triple, let flags and wake settle, then compare the state register
  task automatic smp(input int x, input int y, input int z, input logic [6:0] exp);
    @(posedge clk);
    sv <= 1'b1;
    sx <= x[11:0];
    sy <= y[11:0];
    sz <= z[11:0];
    @(posedge clk);
    sv <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("state", AWD_IDX_STATE, {25'h0, exp});
  endtask : smp

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    {psel, pen, pwrite, mon, sv, mode, andor, cnten} = '0;
    paddr = '0;
    pwdata = '0;
    {sx, sy, sz} = '0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    srst = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // Reset values
    rchk("thr ctrl", AWD_IDX_THR_CTRL, 32'h0);
    rchk("config", AWD_IDX_CONFIG, 32'h0);
    rchk("mask", AWD_IDX_MASK, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    // Each shadow gets its own value; the unused codes hold nothing
    for (int i = 0; i < 8; i++) shw(i[2:0], 6'h38 + i[5:0]);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, AWD_IDX_CONFIG, {29'h0, i[2:0]});
      rchk("shadow", AWD_IDX_THR_CTRL, (i % 4 == 0) ? 32'h0 : 32'h38 + i);
    end
    // Unmapped index is refused
    apb(1'b0, 8'h30, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("bad read", 32'h0, rd);
    // Thresholds X=10, Y=Z=63, counts one event
    shw(3'h1, 6'd10);
    shw(3'h2, 6'h3f);
    shw(3'h3, 6'h3f);
    for (int i = 5; i < 8; i++) shw(i[2:0], 6'h0);
    // Current-to-previous with clamping; 63 threshold never trips even on a huge delta
    enter();
    smp(0, 0, 0, 7'h00);
    smp(70, 2000, 2000, 7'h19);
    smp(80, 2000, 2000, 7'h00);
    smp(90, 2000, 2000, 7'h00);
    // Window one halves the delta: 21 gives slice 10, not above 10
    apb(1'b1, AWD_IDX_CONFIG, 32'h10);
    smp(111, 2000, 2000, 7'h00);
    smp(133, 2000, 2000, 7'h19);
    // Window code seven acts as five: 351 gives slice 10, 352 gives 11
    apb(1'b1, AWD_IDX_CONFIG, 32'h70);
    smp(484, 2000, 2000, 7'h00);
    smp(836, 2000, 2000, 7'h19);
    apb(1'b1, AWD_IDX_CONFIG, 32'h0);
    // Baseline mode: steps of 6 stay quiet until 12 away from the first sample
    mode = 1'b1;
    shw(3'h1, 6'd10);
    enter();
    smp(0, 0, 0, 7'h00);
    smp(6, 0, 0, 7'h00);
    smp(12, 0, 0, 7'h19);
    // AND combining over all axes, then only over X
    mode = 1'b0;
    andor = 1'b1;
    shw(3'h2, 6'd10);
    shw(3'h3, 6'd10);
    enter();
    smp(0, 0, 0, 7'h00);
    smp(20, 0, 0, 7'h11);
    smp(40, 20, 20, 7'h7f);
    apb(1'b1, AWD_IDX_AXIS_CTRL, 32'h60);
    smp(60, 20, 20, 7'h19);
    chk("wake and", 32'h1, {31'h0, wake});
    apb(1'b1, AWD_IDX_AXIS_CTRL, 32'h0);
    // OR with three-event count on X; interrupt on the wake edge
    andor = 1'b0;
    cnten = 1'b1;
    shw(3'h2, 6'h3f);
    shw(3'h3, 6'h3f);
    shw(3'h5, 6'd2);
    apb(1'b1, AWD_IDX_STATUS, 32'hf);
    apb(1'b1, AWD_IDX_MASK, 32'h1);
    enter();
    smp(0, 0, 0, 7'h00);
    smp(20, 0, 0, 7'h10);
    smp(40, 0, 0, 7'h10);
    chk("irq idle", 32'h0, {31'h0, irq});
    smp(60, 0, 0, 7'h19);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("status", AWD_IDX_STATUS, 32'h3);
    apb(1'b1, AWD_IDX_STATUS, 32'h1);
    rchk("status clr", AWD_IDX_STATUS, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, AWD_IDX_MASK, 32'h2);
    @(posedge clk);
    chk("irq x", 32'h1, {31'h0, irq});
    // All axes powered down: flags stay, wake drops
    apb(1'b1, AWD_IDX_AXIS_CTRL, 32'h70);
    rchk("state pd", AWD_IDX_STATE, 32'h11);
    chk("wake pd", 32'h0, {31'h0, wake});
    results();
  end
endmodule : awd_top_test
`default_nettype wire
